// ==== logic/wcd_cfg.svh ====
// Constants for the wiper command decoder: command codes, field positions, reset values, timing.
// Included by the package and the design module; holds definitions only.
`ifndef WCD_CFG_SVH
`define WCD_CFG_SVH
`define WCD_CMD_NOP 4'h0
`define WCD_CMD_WR_WIPER 4'h1
`define WCD_CMD_RD_WIPER 4'h2
`define WCD_CMD_STORE 4'h3
`define WCD_CMD_REFRESH 4'h4
`define WCD_CMD_RD_NVM 4'h5
`define WCD_CMD_WR_CTRL 4'h6
`define WCD_CMD_RD_CTRL 4'h7
`define WCD_CMD_SHUTDOWN 4'h8
`define WCD_CMD_MSB 13
`define WCD_CMD_LSB 10
`define WCD_DATA_MSB 9
`define WCD_FRAME_BITS 16
`define WCD_CTRL_PGM_EN 0
`define WCD_CTRL_UNLOCK 1
`define WCD_CTRL_CAL 2
`define WCD_CTRL_PGM_OK 3
`define WCD_CTRL_RESET 4'h0
`define WCD_WIPER_MID 10'h200
`define WCD_SLOTS 20
`define WCD_STAT_LO 5'h14
`define WCD_STAT_HI 5'h15
`define WCD_PGM_TIME_US 8000
`define WCD_CLK_MHZ 20
`define WCD_PGM_CYCLES (`WCD_PGM_TIME_US * `WCD_CLK_MHZ)
`endif

// ==== logic/wcd_decoder.sv ====
// Serial command decoder and control logic for a digital potentiometer wiper with twenty-slot memory.
// Assumes the frame select, serial clock and data pins are asynchronous to i_clk_sys and much slower.
//
// Function
// (R1) Wiper output follows the wiper register; zero means wiper at terminal B.
// (R2) Wiper register is an ordinary register, rewritable without limit.
// (R3) Frame bits 13..10 hold the command, bits 9..0 the data.
// (R4) Command 1 loads the wiper register when write unlock is set.
// (R5) In the 256-step variant the two low data bits are ignored.
// (R6) Command 2 shifts the wiper value out in the next frame.
// (R7) Command 3 stores the wiper into the next free slot if programming enabled; after a reset the code writes from slot 0 again.
// (R8) Command 4 reloads the wiper from the last programmed slot, ignoring protection; after a reset, until a store, the code loads midscale.
// (R9) Command 5 selects a slot or status word by data bits 4..0 for readback.
// (R10) Command 6 writes data bits 2..0 into control register bits 2..0.
// (R11) Command 7 shifts the control register out in the next frame, low four bits.
// (R12) Command 8 enters shutdown when data bit 0 is 1, leaves it otherwise.
// (R13) Command 0 does nothing but still shifts out prepared readback.
// (R14) Twenty one-time-programmable slots hold wiper values; after a reset the code overwrites them from slot 0.
// (R15) Each program is verified and the result lands in the success bit.
// (R16) Programming takes about 8 ms, locks the shift register, ready marks completion.
// (R17) With no slot programmed the wiper resets to midscale.
// (R18) Write unlock defaults to 0 and then blocks the wiper writes of command 1.
// (R19) Program enable defaults to 0; setting it permits the store command.
// (R20) Calibration select defaults to 0; writing 1 selects normal mode.
// (R21) Success bit defaults to 0 and reads 1 only after a verified program.
// (R22) Control bits: 3 success, 2 calibration, 1 unlock, 0 program enable.
// (R23) Serial data is sampled on the falling serial clock while frame select is low.
// (R24) Frames are 16 bits, MSB first: two zeros, four command, ten data bits.
// (R25) The command executes on frame select rising after the 16th clock.
// (R26) A frame shorter than 16 clocks is discarded.
// (R27) Command codes 9 to 15 change nothing.
// (R28) During programming frames are ignored and ready stays low.
`timescale 1ns/1ps
`include "wcd_cfg.svh"
module wcd_decoder
    import wcd_pkg::*;
#(
    parameter int PGM_CYCLES = `WCD_PGM_CYCLES,
    parameter int VERIFY_CYCLES = 16,
    parameter bit COARSE_256 = 1'b0
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_frame_sel_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_nvm_verify_ok,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_ready,
    output logic o_ready_oe,
    output logic [9:0] o_wiper,
    output logic o_shutdown,
    output logic o_calibration_select,
    output logic o_program_cap_pin
);

    wcd_state_t st;
    wcd_state_t next_st;
    // Slot memory is never erased, like a fuse array, but reset clears used_slots so writing restarts at slot 0.
    logic [9:0] twenty_slot_nvm [0:`WCD_SLOTS-1];
    logic nvm_we;
    logic [4:0] nvm_waddr;

    // Thermometer word of programmed slots; the low word covers slots 0..9, high word 10..19.
    function automatic logic [9:0] wcd_therm(input logic [4:0] count, input logic [4:0] base);
        logic [9:0] t;
        t = 10'h000;
        for (int i = 0; i < 10; i++)
        begin
            t[i] = (5'(i) + base) < count;
        end
        return t;
    endfunction

    // Wiper value with the low bits masked for the coarse variant.
    function automatic logic [9:0] wcd_mask(input logic [9:0] v);
        return COARSE_256 ? {v[9:2], 2'b00} : v; // R5
    endfunction

    always_comb
    begin
        logic sclk_fall;
        logic frame_rise;
        logic frame_fall;
        logic [3:0] cmd;
        logic [9:0] data;
        logic [4:0] sel;
        sclk_fall = 1'b0;
        frame_rise = 1'b0;
        frame_fall = 1'b0;
        cmd = 4'h0;
        data = 10'h000;
        sel = 5'h00;
        next_st = st;
        nvm_we = 1'b0;
        nvm_waddr = st.used_slots;

        next_st.sclk_sync = {st.sclk_sync[0], i_sclk};
        next_st.frame_n_sync = {st.frame_n_sync[0], i_frame_sel_n};
        next_st.din_sync = {st.din_sync[0], i_din};
        next_st.sclk_prev = st.sclk_sync[1];
        next_st.frame_n_prev = st.frame_n_sync[1];
        sclk_fall = st.sclk_prev && !st.sclk_sync[1];
        frame_rise = !st.frame_n_prev && st.frame_n_sync[1];
        frame_fall = st.frame_n_prev && !st.frame_n_sync[1];
        cmd = st.shift_in[`WCD_CMD_MSB:`WCD_CMD_LSB]; // R3 R24
        data = st.shift_in[`WCD_DATA_MSB:0];
        sel = data[4:0];

        case (st.mode)
            WCD_IDLE:
            begin
                if (frame_fall)
                begin
                    next_st.bit_count = 5'd0;
                    next_st.shift_out = {6'h00, st.readback}; // R13
                    // The first bit on the line is bit 15 of the reply, not the top readback bit.
                    next_st.sdo_oe = !next_st.shift_out[15]; // R6
                end
                if (sclk_fall && !st.frame_n_sync[1])
                begin
                    next_st.shift_in = {st.shift_in[14:0], st.din_sync[1]}; // R23
                    next_st.shift_out = {st.shift_out[14:0], 1'b0};
                    next_st.sdo_oe = !st.shift_out[14];
                    if (st.bit_count != 5'd31)
                    begin
                        next_st.bit_count = st.bit_count + 5'd1;
                    end
                end
                if (frame_rise)
                begin
                    next_st.sdo_oe = 1'b0;
                    // Only exactly 16 bits count; 32-bit daisy frames are out of scope.
                    if (st.bit_count == 5'(`WCD_FRAME_BITS)) // R25 R26
                    begin
                        next_st.readback = 10'h000;
                        case (cmd)
                            `WCD_CMD_WR_WIPER:
                            begin
                                if (st.pot_control[`WCD_CTRL_UNLOCK]) // R4 R18
                                begin
                                    next_st.wiper_position_reg = wcd_mask(data); // R2
                                end
                            end
                            `WCD_CMD_RD_WIPER:
                            begin
                                next_st.readback = wcd_mask(st.wiper_position_reg); // R6
                            end
                            `WCD_CMD_STORE:
                            begin
                                // A full array ignores the store.
                                if (st.pot_control[`WCD_CTRL_PGM_EN] && st.used_slots < 5'(`WCD_SLOTS)) // R7 R19
                                begin
                                    next_st.prog_value = st.wiper_position_reg;
                                    next_st.pot_control[`WCD_CTRL_PGM_OK] = 1'b0;
                                    next_st.mode = WCD_PROG;
                                    next_st.ready = 1'b0; // R16
                                    next_st.timer = 18'(PGM_CYCLES - 1);
                                end
                            end
                            `WCD_CMD_REFRESH:
                            begin
                                next_st.wiper_position_reg = (st.used_slots == 5'd0) ? `WCD_WIPER_MID
                                    : twenty_slot_nvm[st.used_slots - 5'd1]; // R8 R17
                            end
                            `WCD_CMD_RD_NVM:
                            begin
                                if (sel == `WCD_STAT_LO) // R9
                                begin
                                    next_st.readback = wcd_therm(st.used_slots, 5'd0);
                                end
                                else if (sel == `WCD_STAT_HI)
                                begin
                                    next_st.readback = wcd_therm(st.used_slots, 5'd10);
                                end
                                else if (sel < st.used_slots)
                                begin
                                    next_st.readback = twenty_slot_nvm[sel];
                                end
                            end
                            `WCD_CMD_WR_CTRL:
                            begin
                                // The success bit is owned by the store and verify steps, so a write leaves it alone.
                                next_st.pot_control[2:0] = data[2:0]; // R10 R20 R21 R22
                            end
                            `WCD_CMD_RD_CTRL:
                            begin
                                next_st.readback = {6'h00, st.pot_control}; // R11
                            end
                            `WCD_CMD_SHUTDOWN:
                            begin
                                next_st.shutdown = data[0]; // R12
                            end
                            default:
                            begin
                                next_st.readback = 10'h000; // R13 R27
                            end
                        endcase
                    end
                end
            end
            WCD_PROG:
            begin
                // Frames arriving now are not shifted in at all.
                next_st.sdo_oe = 1'b0; // R28
                if (st.timer == 18'd0)
                begin
                    nvm_we = 1'b1; // R14
                    next_st.used_slots = st.used_slots + 5'd1;
                    next_st.mode = WCD_VERIFY;
                    next_st.timer = 18'(VERIFY_CYCLES - 1);
                end
                else
                begin
                    next_st.timer = st.timer - 18'd1;
                end
            end
            WCD_VERIFY:
            begin
                if (st.timer == 18'd0)
                begin
                    // The margin read must match and the cell must report a good margin.
                    next_st.pot_control[`WCD_CTRL_PGM_OK] =
                        i_nvm_verify_ok && (twenty_slot_nvm[st.used_slots - 5'd1] == st.prog_value); // R15 R21
                    next_st.mode = WCD_IDLE;
                    next_st.ready = 1'b1; // R16 R28
                    next_st.bit_count = 5'd0;
                end
                else
                begin
                    next_st.timer = st.timer - 18'd1;
                end
            end
            default:
            begin
                next_st.mode = WCD_IDLE;
                next_st.ready = 1'b1;
            end
        endcase
        // Registered so the open-drain enable comes straight from a flip-flop.
        next_st.ready_oe = !next_st.ready; // R16
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st <= '0;
            st.sclk_sync <= 2'b11;
            st.frame_n_sync <= 2'b11;
            st.sclk_prev <= 1'b1;
            st.frame_n_prev <= 1'b1;
            st.pot_control <= `WCD_CTRL_RESET; // R18 R19 R20 R21
            st.wiper_position_reg <= `WCD_WIPER_MID; // R17
            st.mode <= WCD_IDLE;
            st.ready <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (nvm_we)
        begin
            twenty_slot_nvm[nvm_waddr] <= st.prog_value; // R7
        end
    end

    // The slot memory survives reset, so a reset with programmed slots should reload it.
    // Command 4 cannot do that reload, as reset also clears used_slots and command 4 then loads midscale.

    // Open drain outputs: enable high pulls low, so data 0 drives and data 1 releases.
    assign o_sdo = 1'b0;
    assign o_sdo_oe = st.sdo_oe;
    assign o_ready = st.ready;
    assign o_ready_oe = st.ready_oe; // R16
    assign o_wiper = st.wiper_position_reg; // R1
    assign o_shutdown = st.shutdown;
    assign o_calibration_select = st.pot_control[`WCD_CTRL_CAL];
    assign o_program_cap_pin = st.mode[1];

endmodule

// ==== logic/wcd_pkg.sv ====
// Types for the wiper command decoder.
// Assumes wcd_cfg.svh is on the include path.
package wcd_pkg;
`include "wcd_cfg.svh"
    typedef enum logic [2:0]
    {
        WCD_IDLE = 3'b001,
        WCD_PROG = 3'b010,
        WCD_VERIFY = 3'b100
    } wcd_mode_t;

    typedef struct packed
    {
        logic [1:0] sclk_sync;
        logic [1:0] frame_n_sync;
        logic [1:0] din_sync;
        logic sclk_prev;
        logic frame_n_prev;
        logic [15:0] shift_in;
        logic [4:0] bit_count;
        logic [15:0] shift_out;
        logic [9:0] readback;
        logic [9:0] wiper_position_reg;
        logic [3:0] pot_control;
        logic shutdown;
        logic [4:0] used_slots;
        logic [9:0] prog_value;
        wcd_mode_t mode;
        logic [17:0] timer;
        logic ready;
        logic ready_oe;
        logic sdo_oe;
    } wcd_state_t;
endpackage

// ==== tb/wcd_decoder_test.sv ====
// Self-checking bench for the wiper command decoder.
// Assumes the host model and monitor are compiled before this file.
`timescale 1ns/1ps
module wcd_decoder_test;
    import wcd_pkg::*;
    localparam int PGM = 400;
    logic clk, rst, fsn, sclk, din, vok, sdo, sdo_oe, rdy, rdy_oe, sd, cal, cap;
    logic [9:0] wiper;
    logic [9:0] wiper_c;
    logic [15:0] rx;
    int fail_count = 0;
    int n_checks = 0;
    wcd_decoder #(.PGM_CYCLES(PGM)) u_dut
    (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_frame_sel_n(fsn), .i_sclk(sclk), .i_din(din),
        .i_nvm_verify_ok(vok), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_ready(rdy), .o_ready_oe(rdy_oe),
        .o_wiper(wiper), .o_shutdown(sd), .o_calibration_select(cal), .o_program_cap_pin(cap)
    );
    // A coarse copy on the same pins shows the masked low wiper bits.
    wcd_decoder #(.PGM_CYCLES(PGM), .COARSE_256(1'b1)) u_dut_coarse
    (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_frame_sel_n(fsn), .i_sclk(sclk), .i_din(din),
        .i_nvm_verify_ok(vok), .o_sdo(), .o_sdo_oe(), .o_ready(), .o_ready_oe(),
        .o_wiper(wiper_c), .o_shutdown(), .o_calibration_select(), .o_program_cap_pin()
    );
    wcd_spi_host u_host (.i_sdo_line(sdo_oe ? sdo : 1'b1), .o_frame_sel_n(fsn), .o_sclk(sclk), .o_din(din));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic print_verdict();
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] fr(input logic [3:0] c, input logic [9:0] d);
        return {2'b00, c, d};
    endfunction
    task automatic send(input logic [15:0] w);
        u_host.xfer(w, 16, rx);
    endtask
    task automatic rd(input logic [15:0] w, input logic [15:0] exp);
        send(w);
        send(16'h0000);
        chk("readback", rx, exp);
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        while (rdy !== 1'b1 && k < 1000)
        begin
            @(posedge clk);
            k++;
        end
        if (rdy !== 1'b1)
        begin
            fail_count++;
            print_verdict();
        end
    endtask
    task automatic t_reset();
        chk("wiper", 16'(wiper), 16'h0200);
        rd(fr(4'h7, 10'h000), 16'h0000);
    endtask
    task automatic t_protect();
        send(fr(4'h1, 10'h155));
        chk("wiper", 16'(wiper), 16'h0200);
        send(fr(4'h6, 10'h3fe));
        chk("cal", 16'(cal), 16'h0001);
        rd(fr(4'h7, 10'h000), 16'h0006);
    endtask
    task automatic t_wiper();
        send(fr(4'h1, 10'h000));
        chk("wiper", 16'(wiper), 16'h0000);
        send(fr(4'h1, 10'h3ff));
        chk("coarse wiper", 16'(wiper_c), 16'h03fc);
        rd(fr(4'h2, 10'h000), 16'h03ff);
    endtask
    task automatic t_ignore();
        u_host.xfer(fr(4'h1, 10'h0aa), 15, rx);
        chk("wiper", 16'(wiper), 16'h03ff);
        for (int c = 9; c < 16; c++)
            send(fr(4'(c), 10'h155));
        chk("wiper", 16'(wiper), 16'h03ff);
        chk("shutdown", 16'(sd), 16'h0000);
        rd(fr(4'h7, 10'h000), 16'h0006);
    endtask
    task automatic t_shutdown();
        send(fr(4'h8, 10'h001));
        chk("shutdown", 16'(sd), 16'h0001);
        chk("wiper", 16'(wiper), 16'h03ff);
        send(fr(4'h8, 10'h3fe));
        chk("shutdown", 16'(sd), 16'h0000);
    endtask
    task automatic t_store();
        send(fr(4'h1, 10'h123));
        send(fr(4'h3, 10'h000));
        chk("ready", 16'(rdy), 16'h0001);
        send(fr(4'h6, 10'h007));
        vok = 1'b1;
        send(fr(4'h3, 10'h000));
        chk("cap", 16'(cap), 16'h0001);
        send(fr(4'h1, 10'h000));
        wait_rdy();
        chk("wiper", 16'(wiper), 16'h0123);
        rd(fr(4'h7, 10'h000), 16'h000f);
        rd(fr(4'h5, 10'h3e0), 16'h0123);
        rd(fr(4'h5, 10'h014), 16'h0001);
        send(fr(4'h1, 10'h000));
        send(fr(4'h6, 10'h005));
        send(fr(4'h4, 10'h000));
        chk("wiper", 16'(wiper), 16'h0123);
    endtask
    task automatic t_fill();
        vok = 1'b0;
        send(fr(4'h3, 10'h000));
        wait_rdy();
        rd(fr(4'h7, 10'h000), 16'h0005);
        vok = 1'b1;
        for (int s = 2; s < 20; s++)
        begin
            send(fr(4'h3, 10'h000));
            wait_rdy();
        end
        send(fr(4'h3, 10'h000));
        chk("ready", 16'(rdy), 16'h0001);
        rd(fr(4'h5, 10'h015), 16'h03ff);
    endtask
    initial
    begin
        rst = 1'b1;
        vok = 1'b0;
        repeat (8) @(posedge clk);
        #2 rst = 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_protect();
        t_wiper();
        t_ignore();
        t_shutdown();
        t_store();
        t_fill();
        print_verdict();
    end
endmodule
bind wcd_decoder wcd_monitor #(.PGM_CYCLES(PGM_CYCLES), .VERIFY_CYCLES(VERIFY_CYCLES)) u_mon
(
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_frame_sel_n(i_frame_sel_n), .i_sclk(i_sclk),
    .i_din(i_din), .i_nvm_verify_ok(i_nvm_verify_ok), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_ready(o_ready), .o_ready_oe(o_ready_oe), .o_wiper(o_wiper), .o_shutdown(o_shutdown),
    .o_calibration_select(o_calibration_select), .o_program_cap_pin(o_program_cap_pin)
);

// ==== tb/wcd_monitor.sv ====
// Port-level checker for the wiper command decoder.
// Assumes it is bound to wcd_decoder and sees only its ports.
`timescale 1ns/1ps
module wcd_monitor
#(
    parameter int PGM_CYCLES = 160000,
    parameter int VERIFY_CYCLES = 16
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_frame_sel_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_nvm_verify_ok,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic o_ready,
    input wire logic o_ready_oe,
    input wire logic [9:0] o_wiper,
    input wire logic o_shutdown,
    input wire logic o_calibration_select,
    input wire logic o_program_cap_pin
);
    logic [31:0] busy_cnt;
    // Counts busy cycles so the programming time can be judged against the decoder's PGM_CYCLES plus VERIFY_CYCLES.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            busy_cnt <= '0;
        else if (o_ready)
            busy_cnt <= '0;
        else
            busy_cnt <= busy_cnt + 32'h1;
    end
    default clocking dc @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);
    ready_oe_match_a: assert property (o_ready_oe == !o_ready)
        else $error("ready enable is not the inverse of ready");
    reset_values_a: assert property ($fell(i_sys_rst) |-> o_wiper == 10'h200 && o_ready && !o_shutdown
        && !o_calibration_select && !o_program_cap_pin && !o_sdo_oe) else $error("wrong value after reset");
    frame_hold_a: assert property ((!i_frame_sel_n)[*8] |=> $stable(o_wiper) && $stable(o_shutdown)
        && $stable(o_calibration_select)) else $error("state changed inside a frame");
    busy_hold_a: assert property (!o_ready |=> $stable(o_wiper) && $stable(o_shutdown)
        && $stable(o_calibration_select)) else $error("state changed while programming");
    cap_ready_a: assert property ($rose(o_program_cap_pin) |-> $fell(o_ready))
        else $error("ready did not drop with program phase");
    cap_busy_a: assert property (o_program_cap_pin |-> !o_ready)
        else $error("ready high during program phase");
    busy_len_a: assert property ($rose(o_ready) |-> busy_cnt >= PGM_CYCLES + VERIFY_CYCLES
        && busy_cnt <= PGM_CYCLES + VERIFY_CYCLES + 2) else $error("busy time wrong");
    pgm_start_a: assert property ($fell(o_ready) |-> i_frame_sel_n && $past(i_frame_sel_n, 2))
        else $error("programming started without a closed frame");
    sdo_drive_a: assert property ((i_frame_sel_n)[*4] |-> !o_sdo_oe && !o_sdo)
        else $error("data line still driven after the frame closed");
endmodule

// ==== tb/wcd_spi_host.sv ====
// Behavioural serial host driving frame select, clock and data.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module wcd_spi_host
(
    input wire logic i_sdo_line,
    output logic o_frame_sel_n,
    output logic o_sclk,
    output logic o_din
);
    initial
    begin
        o_frame_sel_n = 1'b1;
        o_sclk = 1'b1;
        o_din = 1'b0;
    end
    // Sends n bits of w MSB first; the clock rests high outside frames.
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        #2 o_frame_sel_n = 1'b0;
        for (int i = 15; i > 15 - n; i--)
        begin
            o_din = w[i];
            #200 rx[i] = i_sdo_line;
            o_sclk = 1'b0;
            #200 o_sclk = 1'b1;
        end
        #200 o_frame_sel_n = 1'b1;
        // Released data shows the inverse so no stale bit can pass as valid.
        o_din = ~o_din;
        #600;
    endtask
endmodule
